// ### core/irq_bank_pkg.sv
// constants and types shared by the interrupt flag and enable bank
`default_nettype none
package irq_bank_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 16;
    localparam int unsigned EVT_W  = 3;

    // byte addresses of the registers
    localparam logic [7:0] OFS_FLAG2     = 8'h00;
    localparam logic [7:0] OFS_FLAG3     = 8'h04;
    localparam logic [7:0] OFS_FLAG4     = 8'h08;
    localparam logic [7:0] OFS_EN0       = 8'h0c;
    localparam logic [7:0] OFS_EN1       = 8'h10;
    localparam logic [7:0] OFS_EVT_STAT  = 8'h14;
    localparam logic [7:0] OFS_EVT_MASK  = 8'h18;

    // implemented bits of each register, all others read zero
    localparam logic [15:0] IMPL_FLAG2   = 16'hdfff;
    localparam logic [15:0] IMPL_FLAG3   = 16'h21ff;
    localparam logic [15:0] IMPL_FLAG4   = 16'h00f6;
    localparam logic [15:0] IMPL_EN0     = 16'h7fff;
    localparam logic [15:0] IMPL_EN1     = 16'hfffb;
    localparam logic [15:0] IMPL_EVT     = 16'h0007;

    // event status bit positions
    localparam int unsigned EVT_FLAG2_POS = 0;
    localparam int unsigned EVT_FLAG3_POS = 1;
    localparam int unsigned EVT_FLAG4_POS = 2;

    localparam logic [15:0] REG_RST      = 16'h0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage
`default_nettype wire

// ### core/irq_enable_reg.sv
// software-owned 16-bit register with byte strobes and a mask of implemented bits
`timescale 1ns/100ps
`default_nettype none
module irq_enable_reg #(
    parameter logic [15:0] IMPL = 16'hffff
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // software write
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_strb,
    input  wire logic [15:0] wr_data,
    // register value
    output logic      [15:0] value
);
    import irq_bank_pkg::*;

    logic [15:0] value_r;
    wire  [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire  [15:0] value_nxt = (value_r & ~lane_mask) | (wr_data & lane_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_r <= REG_RST;
        end else if (wr_en) begin
            value_r <= value_nxt & IMPL;
        end
    end

    assign value = value_r;
endmodule
`default_nettype wire

// ### core/irq_flag_reg.sv
// 16 sticky request flags: a source request sets a bit, software may write it
`timescale 1ns/100ps
`default_nettype none
module irq_flag_reg #(
    parameter logic [15:0] IMPL = 16'hffff
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // software write
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_strb,
    input  wire logic [15:0] wr_data,
    // source requests
    input  wire logic [15:0] req,
    // flags and a pulse for any request on an implemented bit
    output wire logic [15:0] flag,
    output wire logic        new_req
);
    import irq_bank_pkg::*;

    for (genvar i = 0; i < 16; i++) begin : g_bit
        if (IMPL[i]) begin : g_impl
            logic bit_r;
            wire  lane_wr = wr_en & wr_strb[i / 8];
            // a request in the cycle of a software clear wins
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    bit_r <= 1'b0;
                end else begin
                    bit_r <= (lane_wr ? wr_data[i] : bit_r) | req[i];
                end
            end
            assign flag[i] = bit_r;
        end else begin : g_unimpl
            assign flag[i] = 1'b0;
        end
    end

    assign new_req = |(req & IMPL);
endmodule
`default_nettype wire

// ### core/irq_bank_top.sv
// interrupt request flag and enable bank behind an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - a flag bit reads 1 once its source has requested and 0 while no request has occurred.
// - an enable bit at 1 passes its source's request on, at 0 holds it back.
// - unimplemented bits of flag and enable registers read zero and ignore writes.
// - every implemented flag and enable bit is read/write and clears at reset.
// - third flag register holds dma5 at 13, can2 event at 8, can2 rx at 7, ext 4/3 at 6/5.
// - third flag register holds timers 9/8 at 4/3, i2c2 master 2, i2c2 slave 1, timer7 0.
// - fourth flag register holds can2/can1 tx at 7/6, dma7/6 at 5/4, uart2/1 error at 2/1.
// - second flag register holds can1 rx at 2, spi2 event at 1, spi2 error at 0.
// - enable register 0 upper byte covers dma1 down to timer3, bit 15 unimplemented.
// - enable register 0 lower byte covers timer2 down to external interrupt 0.
// - enable register 1 upper byte covers uart2 tx down to dma channel 2.
// - enable register 1 lower byte covers ic8 down to i2c1 slave, bit 2 unimplemented.
module irq_bank_top (
    // clock and reset
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // axi4-lite write address
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                      awprot,
    input  wire logic                            awvalid,
    output logic                                 awready,
    // axi4-lite write data
    input  wire logic [irq_bank_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                      wstrb,
    input  wire logic                            wvalid,
    output logic                                 wready,
    // axi4-lite write response
    output logic      [1:0]                      bresp,
    output logic                                 bvalid,
    input  wire logic                            bready,
    // axi4-lite read address
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                      arprot,
    input  wire logic                            arvalid,
    output logic                                 arready,
    // axi4-lite read data
    output logic      [irq_bank_pkg::DATA_W-1:0] rdata,
    output logic      [1:0]                      rresp,
    output logic                                 rvalid,
    input  wire logic                            rready,
    // source requests into the local flag registers
    input  wire logic [irq_bank_pkg::REG_W-1:0]  req_2,
    input  wire logic [irq_bank_pkg::REG_W-1:0]  req_3,
    input  wire logic [irq_bank_pkg::REG_W-1:0]  req_4,
    // neighbouring flag registers gated by the local enables
    input  wire logic [irq_bank_pkg::REG_W-1:0]  flag_in_0,
    input  wire logic [irq_bank_pkg::REG_W-1:0]  flag_in_1,
    // neighbouring enable registers gating the local flags
    input  wire logic [irq_bank_pkg::REG_W-1:0]  enable_in_2,
    input  wire logic [irq_bank_pkg::REG_W-1:0]  enable_in_3,
    input  wire logic [irq_bank_pkg::REG_W-1:0]  enable_in_4,
    // pending requests towards the core
    output logic      [irq_bank_pkg::REG_W-1:0]  pend_0,
    output logic      [irq_bank_pkg::REG_W-1:0]  pend_1,
    output logic      [irq_bank_pkg::REG_W-1:0]  pend_2,
    output logic      [irq_bank_pkg::REG_W-1:0]  pend_3,
    output logic      [irq_bank_pkg::REG_W-1:0]  pend_4,
    // summary interrupt
    output logic                                 irq
);
    import irq_bank_pkg::*;

    // write channel state
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [15:0]       wdata_r;
    logic [1:0]        wstrb_r;

    // read channel state
    logic              arready_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [DATA_W-1:0] rdata_r;

    // block state
    logic [EVT_W-1:0]  evt_status_r;
    logic [REG_W-1:0]  pend_0_r;
    logic [REG_W-1:0]  pend_1_r;
    logic [REG_W-1:0]  pend_2_r;
    logic [REG_W-1:0]  pend_3_r;
    logic [REG_W-1:0]  pend_4_r;
    logic              irq_r;

    // register values
    wire  [15:0] flag2;
    wire  [15:0] flag3;
    wire  [15:0] flag4;
    wire  [15:0] en0;
    wire  [15:0] en1;
    wire  [15:0] evt_mask;
    wire         new_req2;
    wire         new_req3;
    wire         new_req4;

    // write path: address and data are taken in either order
    wire              aw_take   = awvalid & awready_r;
    wire              w_take    = wvalid & wready_r;
    wire              have_aw   = aw_held_r | aw_take;
    wire              have_w    = w_held_r | w_take;
    wire              do_write  = have_aw & have_w;
    wire [ADDR_W-1:0] wr_addr   = aw_held_r ? awaddr_r : awaddr;
    wire [15:0]       wr_dat    = w_held_r ? wdata_r : wdata[15:0];
    wire [1:0]        wr_stb    = w_held_r ? wstrb_r : wstrb[1:0];
    wire [7:0]        wr_word   = {wr_addr[7:2], 2'h0};
    wire              wsel_f2   = do_write & (wr_word == OFS_FLAG2);
    wire              wsel_f3   = do_write & (wr_word == OFS_FLAG3);
    wire              wsel_f4   = do_write & (wr_word == OFS_FLAG4);
    wire              wsel_e0   = do_write & (wr_word == OFS_EN0);
    wire              wsel_e1   = do_write & (wr_word == OFS_EN1);
    wire              wsel_em   = do_write & (wr_word == OFS_EVT_MASK);
    wire              wr_hit    = (wr_word == OFS_FLAG2) | (wr_word == OFS_FLAG3)
                                | (wr_word == OFS_FLAG4) | (wr_word == OFS_EN0)
                                | (wr_word == OFS_EN1) | (wr_word == OFS_EVT_STAT)
                                | (wr_word == OFS_EVT_MASK);
    wire              aw_held_nxt = have_aw & ~do_write;
    wire              w_held_nxt  = have_w & ~do_write;
    wire              bvalid_nxt  = do_write | (bvalid_r & ~bready);

    // read path
    wire              rd_take    = arvalid & arready_r;
    wire [7:0]        rd_word    = {araddr[7:2], 2'h0};
    wire              rvalid_nxt = rd_take | (rvalid_r & ~rready);
    wire              rsel_stat  = rd_take & (rd_word == OFS_EVT_STAT);
    wire [15:0]       rd_mux     = (rd_word == OFS_FLAG2)    ? flag2 :
                                   (rd_word == OFS_FLAG3)    ? flag3 :
                                   (rd_word == OFS_FLAG4)    ? flag4 :
                                   (rd_word == OFS_EN0)      ? en0 :
                                   (rd_word == OFS_EN1)      ? en1 :
                                   (rd_word == OFS_EVT_STAT) ? {13'h0000, evt_status_r} :
                                   (rd_word == OFS_EVT_MASK) ? evt_mask : 16'h0000;
    wire              rd_hit     = (rd_word == OFS_FLAG2) | (rd_word == OFS_FLAG3)
                                 | (rd_word == OFS_FLAG4) | (rd_word == OFS_EN0)
                                 | (rd_word == OFS_EN1) | (rd_word == OFS_EVT_STAT)
                                 | (rd_word == OFS_EVT_MASK);

    // event status: a new request sets, a read clears, the set wins
    wire [EVT_W-1:0]  evt_set    = {new_req4, new_req3, new_req2};
    wire [EVT_W-1:0]  evt_status_nxt = (evt_status_r & ~{EVT_W{rsel_stat}}) | evt_set;

    // flag registers
    irq_flag_reg #(.IMPL(IMPL_FLAG2)) u_flag2 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wsel_f2),
        .wr_strb (wr_stb),
        .wr_data (wr_dat),
        .req     (req_2),
        .flag    (flag2),
        .new_req (new_req2)
    );

    irq_flag_reg #(.IMPL(IMPL_FLAG3)) u_flag3 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wsel_f3),
        .wr_strb (wr_stb),
        .wr_data (wr_dat),
        .req     (req_3),
        .flag    (flag3),
        .new_req (new_req3)
    );

    irq_flag_reg #(.IMPL(IMPL_FLAG4)) u_flag4 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wsel_f4),
        .wr_strb (wr_stb),
        .wr_data (wr_dat),
        .req     (req_4),
        .flag    (flag4),
        .new_req (new_req4)
    );

    // enable registers
    irq_enable_reg #(.IMPL(IMPL_EN0)) u_en0 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wsel_e0),
        .wr_strb (wr_stb),
        .wr_data (wr_dat),
        .value   (en0)
    );

    irq_enable_reg #(.IMPL(IMPL_EN1)) u_en1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wsel_e1),
        .wr_strb (wr_stb),
        .wr_data (wr_dat),
        .value   (en1)
    );

    irq_enable_reg #(.IMPL(IMPL_EVT)) u_evt_mask (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wsel_em),
        .wr_strb (wr_stb),
        .wr_data (wr_dat),
        .value   (evt_mask)
    );

    // write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awready_r <= ~aw_held_nxt & ~bvalid_nxt;
            wready_r  <= ~w_held_nxt & ~bvalid_nxt;
            bvalid_r  <= bvalid_nxt;
            if (do_write) begin
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_r <= '0;
            wdata_r  <= REG_RST;
            wstrb_r  <= 2'h0;
        end else begin
            if (aw_take) begin
                awaddr_r <= awaddr;
            end
            if (w_take) begin
                wdata_r <= wdata[15:0];
                wstrb_r <= wstrb[1:0];
            end
        end
    end

    // read channel; upper half and unimplemented bits read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end else begin
            arready_r <= ~rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (rd_take) begin
                rdata_r <= {16'h0000, rd_mux};
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // pending requests: flag and enable both set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_0_r <= REG_RST;
            pend_1_r <= REG_RST;
            pend_2_r <= REG_RST;
            pend_3_r <= REG_RST;
            pend_4_r <= REG_RST;
        end else begin
            pend_0_r <= flag_in_0 & en0;
            pend_1_r <= flag_in_1 & en1;
            pend_2_r <= flag2 & enable_in_2;
            pend_3_r <= flag3 & enable_in_3;
            pend_4_r <= flag4 & enable_in_4;
        end
    end

    // event status and summary interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_r <= '0;
            irq_r        <= 1'b0;
        end else begin
            evt_status_r <= evt_status_nxt;
            irq_r        <= |(evt_status_r & evt_mask[EVT_W-1:0]);
        end
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;
    assign pend_0  = pend_0_r;
    assign pend_1  = pend_1_r;
    assign pend_2  = pend_2_r;
    assign pend_3  = pend_3_r;
    assign pend_4  = pend_4_r;
    assign irq     = irq_r;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_FLAG_SET: assert property (
        req_3[13] |=> flag3[13]
    ) else $error("flag did not set after a request");

    AST_FLAG_STICKY: assert property (
        flag4[6] && !(wsel_f4 && wr_stb[0]) |=> flag4[6]
    ) else $error("flag dropped without a software write");

    AST_PEND_GATE: assert property (
        !enable_in_3[8] |=> !pend_3[8]
    ) else $error("disabled source passed on");

    AST_PEND_BOTH: assert property (
        flag2[1] && enable_in_2[1] ##1 flag2[1] |-> pend_2[1]
    ) else $error("flagged and enabled source not pending");

    AST_UNIMPL_ZERO: assert property (
        ((flag3 & ~IMPL_FLAG3) == 16'h0000) && ((en0 & ~IMPL_EN0) == 16'h0000)
    ) else $error("unimplemented bit reads nonzero");

    AST_FLAG4_LAYOUT: assert property (
        req_4 == 16'hffff |=> flag4 == IMPL_FLAG4
    ) else $error("fourth flag register layout wrong");

    AST_FLAG2_LOW: assert property (
        req_2[2:0] == 3'h7 |=> flag2[2:0] == 3'h7
    ) else $error("second flag register low bits wrong");

    AST_EN_WRITE: assert property (
        wsel_e0 && wr_stb == 2'h3 |=> en0 == ($past(wr_dat) & IMPL_EN0)
    ) else $error("enable register 0 write not stored");

    AST_EN1_HOLE: assert property (
        wsel_e1 && wr_stb == 2'h3 && wr_dat == 16'hffff |=> en1 == 16'hfffb
    ) else $error("enable register 1 layout wrong");

    AST_RESET_CLEAR: assert property (
        $rose(aresetn) |-> (flag2 | flag3 | flag4 | en0 | en1) == 16'h0000
    ) else $error("register not zero after reset");

    AST_FLAG3_LAYOUT: assert property (
        req_3 == 16'hffff |=> flag3 == IMPL_FLAG3
    ) else $error("third flag register layout wrong");

    AST_BRESP_NEXT: assert property (
        do_write |=> bvalid ##0 !awready && !wready
    ) else $error("write response not one cycle after write");

    COV_WRITE: cover property (do_write ##1 bvalid && bready);
    COV_STAT_READ: cover property (rsel_stat && evt_status_r != 3'h0);
    COV_IRQ: cover property ($rose(irq));
    COV_SET_CLEAR: cover property (wsel_f3 && req_3[0] && wr_stb[0] && !wr_dat[0]);
endmodule
`default_nettype wire

// ### dv/src_model.sv
// behavioural peripheral sources and neighbouring flag and enable holders
`timescale 1ns/100ps
`default_nettype none
module src_model (
    // clock
    input  wire logic        aclk,
    // request levels into the bank
    output logic      [15:0] req_2,
    output logic      [15:0] req_3,
    output logic      [15:0] req_4,
    // flags and enables held outside the bank
    output logic      [15:0] flag_in_0,
    output logic      [15:0] flag_in_1,
    output logic      [15:0] enable_in_2,
    output logic      [15:0] enable_in_3,
    output logic      [15:0] enable_in_4
);
    initial begin
        {req_2, req_3, req_4} = '0;
        {flag_in_0, flag_in_1, enable_in_2, enable_in_3, enable_in_4} = '0;
    end
    // one-cycle request pulse, then the source lines return to idle low
    task automatic raise(input int k, input logic [15:0] bits);
        @(posedge aclk);
        req_2 <= (k == 0) ? bits : 16'h0000;
        req_3 <= (k == 1) ? bits : 16'h0000;
        req_4 <= (k == 2) ? bits : 16'h0000;
        @(posedge aclk);
        {req_2, req_3, req_4} <= '0;
    endtask
    task automatic set_side(input logic [15:0] f0, f1, e2, e3, e4);
        @(posedge aclk);
        flag_in_0   <= f0;
        flag_in_1   <= f1;
        enable_in_2 <= e2;
        enable_in_3 <= e3;
        enable_in_4 <= e4;
    endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import irq_bank_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    wire  [15:0] req_2, req_3, req_4, flag_in_0, flag_in_1;
    wire  [15:0] enable_in_2, enable_in_3, enable_in_4;
    logic [15:0] pend_0, pend_1, pend_2, pend_3, pend_4;
    logic [79:0] rq[$];
    logic [1:0]  wq[$];
    logic [15:0] sh[5], sd[5], m;
    logic [7:0]  ofs[5];
    logic [1:0]  s;
    logic        hit;
    int          bad_count, checks_done, cyc, i, k, b;
    integer      seed;

    irq_bank_top irq_bank_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .req_2(req_2), .req_3(req_3),
        .req_4(req_4), .flag_in_0(flag_in_0), .flag_in_1(flag_in_1),
        .enable_in_2(enable_in_2), .enable_in_3(enable_in_3), .enable_in_4(enable_in_4),
        .pend_0(pend_0), .pend_1(pend_1), .pend_2(pend_2), .pend_3(pend_3),
        .pend_4(pend_4), .irq(irq));
    src_model src_model_i (.aclk(aclk), .req_2(req_2), .req_3(req_3), .req_4(req_4),
        .flag_in_0(flag_in_0), .flag_in_1(flag_in_1), .enable_in_2(enable_in_2),
        .enable_in_3(enable_in_3), .enable_in_4(enable_in_4));

    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] st,
                      input logic [1:0] e);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        wq.push_back(e);
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'h1;
        wdata   <= {16'h0000, d};
        wstrb   <= {2'h0, st};
        wvalid  <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
        rq.push_back({46'h0, e, 16'h0000, d});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        rready  <= 1'h1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
    endtask

    // results are matched against the oldest note when the handshake completes
    always @(posedge aclk) begin
        if (rvalid && rready) check({46'h0, rresp, rdata}, rq.pop_front());
        if (bvalid && bready) check({78'h0, bresp}, {78'h0, wq.pop_front()});
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        seed = 32'h53512ca7;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        ofs = '{OFS_FLAG2, OFS_FLAG3, OFS_FLAG4, OFS_EN0, OFS_EN1};
        aresetn = 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 7; i++) rd(8'(4 * i), 16'h0000, RESP_OKAY);
        rd(8'h1c, 16'h0000, RESP_SLVERR);
        wr(8'h1c, 16'hffff, 2'h3, RESP_SLVERR);
        wr(OFS_EVT_STAT, 16'hffff, 2'h3, RESP_OKAY);
        rd(OFS_EVT_STAT, 16'h0000, RESP_OKAY);
        for (i = 0; i < 5; i++) begin
            sh[i] = (i == 0) ? IMPL_FLAG2 : (i == 1) ? IMPL_FLAG3 : (i == 2) ? IMPL_FLAG4 :
                    (i == 3) ? IMPL_EN0 : IMPL_EN1;
            wr(ofs[i], 16'hffff, 2'h3, RESP_OKAY);
            rd(ofs[i], sh[i], RESP_OKAY);
            sd[i] = sh[i];
            m = 16'($random(seed));
            s = 2'($random(seed));
            wr(ofs[i], m, s, RESP_OKAY);
            m = (m & {{8{s[1]}}, {8{s[0]}}}) | (sh[i] & ~{{8{s[1]}}, {8{s[0]}}});
            sh[i] = m & sd[i];
            rd(ofs[i], sh[i], RESP_OKAY);
        end
        wr(OFS_EVT_MASK, 16'h0007, 2'h3, RESP_OKAY);
        rd(OFS_EVT_MASK, 16'h0007, RESP_OKAY);
        for (k = 0; k < 3; k++) wr(ofs[k], 16'h0000, 2'h3, RESP_OKAY);
        // a single request on every bit position, implemented or not
        for (k = 0; k < 3; k++) for (b = 0; b < 16; b++) begin
            hit = sd[k][b];
            src_model_i.raise(k, 16'h0001 << b);
            repeat (2) @(posedge aclk);
            check({79'h0, irq}, {79'h0, hit});
            rd(ofs[k], hit ? 16'h0001 << b : 16'h0000, RESP_OKAY);
            rd(OFS_EVT_STAT, 16'(hit) << k, RESP_OKAY);
            @(posedge aclk);
            check({79'h0, irq}, 80'h0);
            wr(ofs[k], 16'h0000, 2'h3, RESP_OKAY);
        end
        // every source at once, in the same edge as a software clear: the request wins
        for (k = 0; k < 3; k++) begin
            fork
                wr(ofs[k], 16'h0000, 2'h3, RESP_OKAY);
                src_model_i.raise(k, 16'hffff);
            join
            rd(ofs[k], sd[k], RESP_OKAY);
            rd(OFS_EVT_STAT, 16'h0001 << k, RESP_OKAY);
            wr(ofs[k], 16'h0000, 2'h3, RESP_OKAY);
        end
        // pending needs flag and enable together; dropping the enable keeps the flag
        for (i = 0; i < 4; i++) begin
            for (k = 0; k < 5; k++) begin
                sd[k] = 16'($random(seed));
                m = 16'($random(seed));
                sh[k] = m & ((k == 0) ? IMPL_FLAG2 : (k == 1) ? IMPL_FLAG3 :
                        (k == 2) ? IMPL_FLAG4 : (k == 3) ? IMPL_EN0 : IMPL_EN1);
                wr(ofs[k], m, 2'h3, RESP_OKAY);
            end
            src_model_i.set_side(sd[0], sd[1], sd[2], sd[3], sd[4]);
            repeat (3) @(posedge aclk);
            check({pend_0, pend_1, pend_2, pend_3, pend_4}, {sd[0] & sh[3], sd[1] & sh[4],
                sh[0] & sd[2], sh[1] & sd[3], sh[2] & sd[4]});
            src_model_i.set_side(sd[0], sd[1], 16'h0000, 16'h0000, 16'h0000);
            wr(ofs[3], 16'h0000, 2'h3, RESP_OKAY);
            wr(ofs[4], 16'h0000, 2'h3, RESP_OKAY);
            repeat (3) @(posedge aclk);
            check({pend_0, pend_1, pend_2, pend_3, pend_4}, 80'h0);
            for (k = 0; k < 3; k++) rd(ofs[k], sh[k], RESP_OKAY);
        end
        repeat (4) @(posedge aclk);
        stop_test();
    end
endmodule
`default_nettype wire
